// ### rtl/ridc_cfg.svh
// Constants for the receive/transmit interrupt daisy chain.
`ifndef RIDC_CFG_SVH
`define RIDC_CFG_SVH

// Cause counts per half
`define RIDC_RX_CAUSES 9
`define RIDC_TX_CAUSES 6
// Vector layout: base in bits 7:4, cause index in bits 3:0
`define RIDC_VEC_IDX_W 4
`define RIDC_RX_VEC_BASE 4'h1
`define RIDC_TX_VEC_BASE 4'h2
// Response reset value
`define RIDC_VEC_RST 8'h00
// Line clock divide count; unused, line_tick comes from line_clock edges
`define RIDC_LINE_DIV 8'h04

`endif

// ### rtl/ridc_pkg.sv
// Types shared by the interrupt daisy-chain design.
package ridc_pkg;
   typedef logic [7:0] ridc_vec_t;
   typedef enum logic [1:0] {
      RIDC_IDLE,
      RIDC_ANSWER,
      RIDC_WAIT_REL
   } ridc_ack_e;
endpackage

// ### rtl/ridc_half.sv
// One half (receive or transmit) of the interrupt daisy chain.
`include "ridc_cfg.svh"

module ridc_half #(
   parameter int N = 9,
   parameter logic [3:0] BASE = 4'h1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [N-1:0] cause_set,
   input wire logic [N-1:0] cause_clr,
   input wire logic enable_in_n,
   input wire logic ack_n,
   output logic req_oe,
   output logic enable_out_n,
   output logic vec_valid,
   output ridc_pkg::ridc_vec_t vec
);
   // ----------------------------------------------------------------
   // Pending causes
   // ----------------------------------------------------------------
   logic [N-1:0] pend_q;
   logic [N-1:0] taken;
   logic ien_s1_q, ien_s2_q, ack_s1_q, ack_s2_q;
   ridc_pkg::ridc_ack_e st_q;

   // Lowest index wins; returns one-hot of the winner
   function automatic logic [N-1:0] pick(input logic [N-1:0] p);
      logic [N-1:0] r;
      r = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (p[i]) begin
            r = '0;
            r[i] = 1'b1;
         end
      end
      return r;
   endfunction

   function automatic logic [3:0] idx(input logic [N-1:0] oh);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 0; i < N; i++) begin
         if (oh[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   // Set wins over clear, so a fresh event is never lost
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_pend
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               pend_q[g] <= 1'b0;
            end else if (cause_set[g]) begin
               pend_q[g] <= 1'b1;
            end else if (cause_clr[g] || taken[g]) begin
               pend_q[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // Pin inputs pass two flops before use
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ien_s1_q <= 1'b1;
         ien_s2_q <= 1'b1;
         ack_s1_q <= 1'b1;
         ack_s2_q <= 1'b1;
      end else begin
         ien_s1_q <= enable_in_n;
         ien_s2_q <= ien_s1_q;
         ack_s1_q <= ack_n;
         ack_s2_q <= ack_s1_q;
      end
   end

   // Acknowledge cycle: answer once, then wait for release
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= ridc_pkg::RIDC_IDLE;
      end else begin
         unique case (st_q)
            ridc_pkg::RIDC_IDLE: begin
               if (!ack_s2_q) begin
                  st_q <= ridc_pkg::RIDC_ANSWER;
               end
            end
            ridc_pkg::RIDC_ANSWER: st_q <= ridc_pkg::RIDC_WAIT_REL;
            ridc_pkg::RIDC_WAIT_REL: begin
               if (ack_s2_q) begin
                  st_q <= ridc_pkg::RIDC_IDLE;
               end
            end
         endcase
      end
   end

   // Respond only with enable-in and a pending request
   wire answer = (st_q == ridc_pkg::RIDC_ANSWER) && !ien_s2_q
                 && (|pend_q);
   assign taken = answer ? pick(pend_q) : '0;

   // Outputs are registered; request is open drain
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_oe <= 1'b0;
         enable_out_n <= 1'b1;
         vec_valid <= 1'b0;
         vec <= `RIDC_VEC_RST;
      end else begin
         req_oe <= |pend_q;
         // Pass enable down only when nobody above or here asks
         enable_out_n <= ien_s2_q || (|pend_q);
         if (answer) begin
            // Highest-priority cause gives the vector
            vec <= {BASE, idx(pick(pend_q))};
            vec_valid <= 1'b1;
         end else if (ack_s2_q) begin
            vec_valid <= 1'b0;
         end
      end
   end
endmodule

// ### rtl/ridc_top.sv
// Top of the receive/transmit interrupt daisy-chain block.
`include "ridc_cfg.svh"

// Contract
// - Transmit enable-out low only if neither we nor higher devices ask.
// - Receive pending interrupt shown on open-drain receive request.
// - Receive request from eight valid-message causes and one bad parity.
// - Receive acknowledge acts like transmit one, returning best vector.
// - Receive enable chain behaves like the transmit chain, independently.
// - Active-low reset returns all interrupt state to initial values.
// - Acknowledge handling runs on the system clock.
// - Serial message timing comes from a separate line clock input.
// - Acknowledge with request active returns highest-priority vector.
// - Vector goes on data lines 7:0 with transfer acknowledge asserted.
// - Transmit request from six causes: FIFO empty, end of transmission.
module ridc_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic reset_n,
   input wire logic line_clock,
   input wire logic [7:0] rx_valid_msg,
   input wire logic rx_bad_parity,
   input wire logic [7:0] rx_clear,
   input wire logic rx_parity_clear,
   input wire logic [2:0] tx_fifo_empty,
   input wire logic [2:0] tx_end_of_tx,
   input wire logic [5:0] tx_clear,
   input wire logic rx_interrupt_acknowledge_n,
   input wire logic rx_chain_enable_in_n,
   input wire logic tx_interrupt_acknowledge_n,
   input wire logic tx_chain_enable_in_n,
   output logic rx_interrupt_request_o,
   output logic rx_interrupt_request_oe,
   output logic tx_interrupt_request_o,
   output logic tx_interrupt_request_oe,
   output logic rx_chain_enable_out_n,
   output logic tx_chain_enable_out_n,
   output logic [7:0] data_o,
   output logic [7:0] data_oe,
   output logic transfer_acknowledge_n,
   output logic line_tick
);
   // ----------------------------------------------------------------
   // Reset: pin reset joins the system reset
   // ----------------------------------------------------------------
   logic rpin_s1_q, rpin_s2_q, lrst;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rpin_s1_q <= 1'b0;
         rpin_s2_q <= 1'b0;
      end else begin
         rpin_s1_q <= reset_n;
         rpin_s2_q <= rpin_s1_q;
      end
   end
   // Reset asserted asynchronously, released after sync
   assign lrst = rst || !reset_n || !rpin_s2_q;

   // ----------------------------------------------------------------
   // Line clock tick, sampled then edge detected
   // ----------------------------------------------------------------
   logic lc_s1_q, lc_s2_q, lc_s3_q;
   always_ff @(posedge clk or posedge lrst) begin
      if (lrst) begin
         lc_s1_q <= 1'b0;
         lc_s2_q <= 1'b0;
         lc_s3_q <= 1'b0;
         line_tick <= 1'b0;
      end else begin
         lc_s1_q <= line_clock;
         lc_s2_q <= lc_s1_q;
         lc_s3_q <= lc_s2_q;
         line_tick <= lc_s2_q && !lc_s3_q;
      end
   end

   // ----------------------------------------------------------------
   // Receive and transmit halves
   // ----------------------------------------------------------------
   logic rx_oe, tx_oe, rx_vv, tx_vv;
   ridc_pkg::ridc_vec_t rx_vec, tx_vec;

   // Cause order sets priority: channel 1 highest, parity last
   ridc_half #(.N(`RIDC_RX_CAUSES), .BASE(`RIDC_RX_VEC_BASE)) u_rx (
      .clk(clk),
      .rst(lrst),
      .cause_set({rx_bad_parity, rx_valid_msg}),
      .cause_clr({rx_parity_clear, rx_clear}),
      .enable_in_n(rx_chain_enable_in_n),
      .ack_n(rx_interrupt_acknowledge_n),
      .req_oe(rx_oe),
      .enable_out_n(rx_chain_enable_out_n),
      .vec_valid(rx_vv),
      .vec(rx_vec)
   );

   // Two causes per channel, interleaved empty/end
   ridc_half #(.N(`RIDC_TX_CAUSES), .BASE(`RIDC_TX_VEC_BASE)) u_tx (
      .clk(clk),
      .rst(lrst),
      .cause_set({tx_end_of_tx[2], tx_fifo_empty[2],
                  tx_end_of_tx[1], tx_fifo_empty[1],
                  tx_end_of_tx[0], tx_fifo_empty[0]}),
      .cause_clr(tx_clear),
      .enable_in_n(tx_chain_enable_in_n),
      .ack_n(tx_interrupt_acknowledge_n),
      .req_oe(tx_oe),
      .enable_out_n(tx_chain_enable_out_n),
      .vec_valid(tx_vv),
      .vec(tx_vec)
   );

   // Open-drain request pins pull low only
   always_ff @(posedge clk or posedge lrst) begin
      if (lrst) begin
         rx_interrupt_request_o <= 1'b0;
         tx_interrupt_request_o <= 1'b0;
         rx_interrupt_request_oe <= 1'b0;
         tx_interrupt_request_oe <= 1'b0;
      end else begin
         rx_interrupt_request_o <= 1'b0;
         tx_interrupt_request_o <= 1'b0;
         rx_interrupt_request_oe <= rx_oe;
         tx_interrupt_request_oe <= tx_oe;
      end
   end

   // ----------------------------------------------------------------
   // Vector onto data lines 7:0 with transfer acknowledge
   // ----------------------------------------------------------------
   // Receive wins if both acknowledges overlap; host should not do so
   always_ff @(posedge clk or posedge lrst) begin
      if (lrst) begin
         data_o <= `RIDC_VEC_RST;
         data_oe <= 8'h00;
         transfer_acknowledge_n <= 1'b1;
      end else begin
         if (rx_vv) begin
            data_o <= rx_vec;
         end else if (tx_vv) begin
            data_o <= tx_vec;
         end
         data_oe <= {8{rx_vv || tx_vv}};
         transfer_acknowledge_n <= !(rx_vv || tx_vv);
      end
   end
endmodule

// ### verification/ridc_top_monitor.sv
// Port checker for the interrupt daisy-chain top.
module ridc_top_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire logic reset_n,
   input wire logic line_clock,
   input wire logic rx_interrupt_acknowledge_n,
   input wire logic tx_interrupt_acknowledge_n,
   input wire logic rx_chain_enable_in_n,
   input wire logic tx_chain_enable_in_n,
   input wire logic rx_interrupt_request_o,
   input wire logic rx_interrupt_request_oe,
   input wire logic rx_chain_enable_out_n,
   input wire logic tx_chain_enable_out_n,
   input wire logic [7:0] data_o,
   input wire logic [7:0] data_oe,
   input wire logic transfer_acknowledge_n,
   input wire logic line_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   // --------------------
   // Checks
   // --------------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_req_open_drain: assert property (
      !rx_interrupt_request_o)
      else $error("rx request drives high");
   chk_tx_chain_block: assert property (
      tx_chain_enable_in_n [*5] |-> tx_chain_enable_out_n)
      else $error("tx enable passed while blocked");
   chk_rx_chain_block: assert property (
      rx_chain_enable_in_n [*5] |-> rx_chain_enable_out_n)
      else $error("rx enable passed while blocked");
   chk_ack_drives_bus: assert property (
      !transfer_acknowledge_n |-> data_oe == 8'hFF)
      else $error("vector not driven");
   chk_vector_base: assert property (
      !transfer_acknowledge_n |-> data_o[7:4] inside {4'h1, 4'h2})
      else $error("bad vector base");
   // Two sync flops, state step and two output flops put the answer 5 edges out
   chk_rx_ack_answer: assert property (
      $fell(rx_interrupt_acknowledge_n) && rx_interrupt_request_oe
      && !rx_chain_enable_in_n && reset_n
      |-> ##[3:8] (!transfer_acknowledge_n && data_o[7:4] == 4'h1))
      else $error("rx acknowledge not answered");
   chk_idle_no_ack: assert property (
      (rx_interrupt_acknowledge_n && tx_interrupt_acknowledge_n) [*8]
      |-> transfer_acknowledge_n)
      else $error("answer without acknowledge");
   chk_reset_idle: assert property (
      !reset_n |-> transfer_acknowledge_n && !rx_interrupt_request_oe
      && data_oe == 8'h00)
      else $error("outputs busy in reset");
   chk_line_tick: assert property (
      $rose(line_clock) |-> ##[1:4] line_tick)
      else $error("line edge lost");
endmodule
bind ridc_top ridc_top_monitor u_mon (.*);

// ### verification/ridc_host_model.sv
// Host and upstream chain peer facing the daisy-chain block.
module ridc_host_model (
   input wire logic rx_go,
   input wire logic tx_go,
   input wire logic rx_up_busy,
   input wire logic tx_up_busy,
   output logic rx_interrupt_acknowledge_n,
   output logic tx_interrupt_acknowledge_n,
   output logic rx_chain_enable_in_n,
   output logic tx_chain_enable_in_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // --------------------
   // Chain and acknowledge pins
   // --------------------
   // Enable-in low only while no upstream peer requests
   assign tx_chain_enable_in_n = tx_up_busy;
   assign rx_chain_enable_in_n = rx_up_busy;
   // Acknowledge held as long as the host asks
   assign rx_interrupt_acknowledge_n = !rx_go;
   assign tx_interrupt_acknowledge_n = !tx_go;
endmodule

// ### verification/ridc_top_tb.sv
// Self-checking bench for the interrupt daisy-chain top.
module ridc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, reset_n = 1'b1, line_clock = 1'b0;
   logic rx_bad_parity = 1'b0, rx_parity_clear = 1'b0;
   logic rx_go = 1'b0, tx_go = 1'b0, rx_up_busy = 1'b0, tx_up_busy = 1'b0;
   logic [7:0] rx_valid_msg = 8'h00, rx_clear = 8'h00;
   logic [2:0] tx_fifo_empty = 3'h0, tx_end_of_tx = 3'h0;
   logic [5:0] tx_clear = 6'h00;
   logic rx_interrupt_acknowledge_n, tx_interrupt_acknowledge_n;
   logic rx_chain_enable_in_n, tx_chain_enable_in_n;
   logic rx_interrupt_request_o, rx_interrupt_request_oe;
   logic tx_interrupt_request_o, tx_interrupt_request_oe;
   logic rx_chain_enable_out_n, tx_chain_enable_out_n;
   logic [7:0] data_o, data_oe;
   logic transfer_acknowledge_n, line_tick;
   int mismatches = 0;
   int checks_done = 0;
   int ticks = 0;
   ridc_top DUT (.*);
   ridc_host_model u_host (.*);
   // --------------------
   // Clock, tasks and sequence
   // --------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Count line ticks seen by the design
   always @(negedge clk) if (line_tick === 1'b1) ticks++;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // One acknowledge, held until answered, bounded wait
   task automatic ack_once(input logic rx, input logic [7:0] exp);
      int n = 0;
      rx_go = rx;
      tx_go = !rx;
      while (transfer_acknowledge_n !== 1'b0 && n < 20) begin
         @(negedge clk);
         n++;
      end
      check(data_o, exp);
      check(data_oe, 8'hFF);
      rx_go = 1'b0;
      tx_go = 1'b0;
      repeat (8) @(negedge clk);
   endtask
   task automatic t_reset();
      check(transfer_acknowledge_n, 1'b1);
      rx_valid_msg = 8'h01;
      @(negedge clk);
      rx_valid_msg = 8'h00;
      repeat (4) @(negedge clk);
      check(rx_interrupt_request_oe, 1'b1);
      reset_n = 1'b0;
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      check(rx_interrupt_request_oe, 1'b0);
      $display("test reset done");
   endtask
   task automatic t_rx();
      rx_valid_msg = 8'hFF;
      rx_bad_parity = 1'b1;
      @(negedge clk);
      rx_valid_msg = 8'h00;
      rx_bad_parity = 1'b0;
      repeat (4) @(negedge clk);
      check(rx_chain_enable_out_n, 1'b1);
      for (int i = 0; i < 9; i++) ack_once(1'b1, {4'h1, 4'(i)});
      check(rx_interrupt_request_oe, 1'b0);
      check(rx_chain_enable_out_n, 1'b0);
      $display("test rx vectors done");
   endtask
   task automatic t_tx();
      tx_fifo_empty = 3'h7;
      tx_end_of_tx = 3'h7;
      @(negedge clk);
      tx_fifo_empty = 3'h0;
      tx_end_of_tx = 3'h0;
      repeat (4) @(negedge clk);
      check(tx_chain_enable_out_n, 1'b1);
      check(tx_interrupt_request_oe, 1'b1);
      check(tx_interrupt_request_o, 1'b0);
      for (int i = 0; i < 6; i++) ack_once(1'b0, {4'h2, 4'(i)});
      check(tx_interrupt_request_oe, 1'b0);
      check(tx_chain_enable_out_n, 1'b0);
      $display("test tx vectors done");
   endtask
   // Upstream busy blocks the answer; then clears
   task automatic t_chain();
      tx_up_busy = 1'b1;
      rx_up_busy = 1'b1;
      repeat (5) @(negedge clk);
      check(tx_chain_enable_out_n, 1'b1);
      check(rx_chain_enable_out_n, 1'b1);
      tx_fifo_empty = 3'h2;
      @(negedge clk);
      tx_fifo_empty = 3'h0;
      tx_go = 1'b1;
      repeat (12) @(negedge clk);
      check(transfer_acknowledge_n, 1'b1);
      tx_go = 1'b0;
      tx_up_busy = 1'b0;
      rx_up_busy = 1'b0;
      repeat (8) @(negedge clk);
      ack_once(1'b0, 8'h22);
      rx_valid_msg = 8'h08;
      rx_bad_parity = 1'b1;
      @(negedge clk);
      rx_valid_msg = 8'h00;
      rx_bad_parity = 1'b0;
      rx_clear = 8'h08;
      rx_parity_clear = 1'b1;
      @(negedge clk);
      rx_clear = 8'h00;
      rx_parity_clear = 1'b0;
      repeat (4) @(negedge clk);
      check(rx_interrupt_request_oe, 1'b0);
      // Set and clear in one cycle: the set must win
      rx_valid_msg = 8'h04;
      rx_clear = 8'h04;
      @(negedge clk);
      rx_valid_msg = 8'h00;
      rx_clear = 8'h00;
      repeat (4) @(negedge clk);
      check(rx_interrupt_request_oe, 1'b1);
      ack_once(1'b1, 8'h12);
      // Acknowledge with nothing pending gets no answer
      rx_go = 1'b1;
      repeat (10) @(negedge clk);
      check(transfer_acknowledge_n, 1'b1);
      rx_go = 1'b0;
      repeat (6) @(negedge clk);
      $display("test chain done");
   endtask
   task automatic t_line();
      ticks = 0;
      for (int i = 0; i < 4; i++) begin
         line_clock = 1'b1;
         repeat (3) @(negedge clk);
         line_clock = 1'b0;
         repeat (3) @(negedge clk);
      end
      repeat (4) @(negedge clk);
      check(8'(ticks), 8'h04);
      $display("test line done");
   endtask
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      t_reset();
      t_rx();
      t_tx();
      t_chain();
      t_line();
      print_verdict();
   end
   // Watchdog: run needs well under a thousand cycles
   initial begin
      #(3000 * 8);
      mismatches++;
      print_verdict();
   end
endmodule
